//--- design/tcds_crc32.v
// Ethernet CRC-32 next state for one byte
`timescale 1ns/10ps
`include "tcds_defs.vh"
module tcds_crc32 (
  input  wire [31:0] crc_in,
  input  wire [7:0]  data,
  output reg  [31:0] crc_out
);
  integer i;
  always @* begin
    crc_out = crc_in;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[0] ^ data[i])
        crc_out = {1'b0, crc_out[31:1]} ^ `TCDS_CRC_POLY;
      else
        crc_out = {1'b0, crc_out[31:1]};
    end
  end
endmodule // tcds_crc32

//--- design/tcds_defs.vh
// Constants for the two-step TC and OAM delay stamper
`ifndef TCDS_DEFS_VH
`define TCDS_DEFS_VH

// ****************************************
// Frame type codes
// ****************************************
`define TCDS_ETH_VLAN      16'h8100
`define TCDS_ETH_QINQ      16'h88a8
`define TCDS_ETH_PTP       16'h88f7
`define TCDS_ETH_OAM       16'h8902
`define TCDS_ETH_MPLS      16'h8847
`define TCDS_ACH_OAM       16'h8902
`define TCDS_ACH_NIBBLE    4'h1
`define TCDS_PTP_SYNC      4'h0
`define TCDS_PTP_DREQ      4'h1
`define TCDS_OP_1DM        8'h2d
`define TCDS_OP_DMM        8'h2f
`define TCDS_OP_REPLY_DEF  8'h2e

// ****************************************
// Byte positions (frame and PDU relative)
// ****************************************
`define TCDS_ETYPE_POS     11'd12
`define TCDS_VLAN_BYTES    11'd4
`define TCDS_MPLS_BYTES    11'd4
`define TCDS_MAX_VLAN      2'd2
`define TCDS_MAX_LABEL     2'd3
`define TCDS_PTP_TYPE_REL  11'd0
`define TCDS_PTP_DOM_REL   11'd4
`define TCDS_PTP_CF_REL    11'd8
`define TCDS_PTP_CF_END    11'd15
`define TCDS_PTP_RSV_REL   11'd16
`define TCDS_PTP_RSV_END   11'd19
`define TCDS_PTP_PORT_REL  11'd28
`define TCDS_PTP_SEQ_END   11'd31
`define TCDS_OAM_MEL_REL   11'd0
`define TCDS_OAM_OP_REL    11'd1
`define TCDS_OAM_TXF_REL   11'd4
`define TCDS_OAM_RXF_REL   11'd12
`define TCDS_OAM_TXB_REL   11'd20
`define TCDS_OAM_RXB_REL   11'd28

// ****************************************
// Field sizes and arithmetic
// ****************************************
`define TCDS_RSV_BYTES     4'd4
`define TCDS_STAMP_BYTES   4'd8
`define TCDS_CF_BYTES      4'd8
`define TCDS_FCS_BYTES     11'd4
`define TCDS_ID_BITS       80
`define TCDS_NS_PER_SEC    32'h3b9aca00
`define TCDS_CRC_INIT      32'hffffffff
`define TCDS_CRC_POLY      32'hedb88320
`define TCDS_LEAD_DEF      8
`define TCDS_FIFO_DEPTH    8
`define TCDS_FIFO_AW       3

`endif

//--- design/tcds_stamp.v
// Stamp unit: captures local time at start of frame, builds adjusted time
`timescale 1ns/10ps
`include "tcds_defs.vh"
module tcds_stamp (
  input  wire        clk,
  input  wire        rst,
  input  wire        sof,
  input  wire [31:0] time_sec,
  input  wire [31:0] time_ns,
  input  wire [29:0] offset,
  input  wire [29:0] asym,
  input  wire        subtract,
  input  wire        minus_asym,
  input  wire        save_req,
  output wire [31:0] stamp_sec,
  output wire [31:0] stamp_ns,
  output reg         save_flag
);
  reg  [31:0] cap_sec_reg;
  reg  [31:0] cap_ns_reg;
  wire [33:0] off34 = {4'h0, offset};
  wire [33:0] asy34 = {4'h0, asym};
  wire [33:0] off_sel = subtract ? (~off34 + 34'd1) : off34;
  wire [33:0] sum = {2'b00, cap_ns_reg} + off_sel - (minus_asym ? asy34 : 34'd0);
  wire        under = sum[33];
  wire        over = !under && (sum[31:0] >= `TCDS_NS_PER_SEC);

  // Time caught at the start-of-frame instant
  always @(posedge clk) begin
    if (rst) begin
      cap_sec_reg <= 32'h0;
      cap_ns_reg  <= 32'h0;
      save_flag   <= 1'b0;
    end else begin
      if (sof) begin // [RULE19]
        cap_sec_reg <= time_sec;
        cap_ns_reg  <= time_ns;
      end
      save_flag <= save_req; // [RULE7]
    end
  end

  // Wrap nanoseconds into the seconds field
  assign stamp_ns  = under ? (sum[31:0] + `TCDS_NS_PER_SEC) :
                     over  ? (sum[31:0] - `TCDS_NS_PER_SEC) : sum[31:0]; // [RULE13]
  assign stamp_sec = under ? (cap_sec_reg - 32'd1) :
                     over  ? (cap_sec_reg + 32'd1) : cap_sec_reg;
endmodule // tcds_stamp

//--- design/tcds_stamper.v
// Two-step TC and OAM delay stamper: analyzer, rewriter, Tx stamp FIFO
//
// What this block does
// (RULE1) Ingress in-domain Sync/Delay_req get Write to reserved
// (RULE2) Ingress Write stores nanoseconds, then new FCS
// (RULE3) Ingress Sync: reserved minus offset, CF plus asymmetry
// (RULE4) Egress Sync/Delay_req: Write-Save, zero-size correction write
// (RULE5) Egress event frame: ten-byte identifier with sequence id
// (RULE6) Egress clears reserved bytes holding Rx stamp
// (RULE7) Write-Save presents time and raises save flag
// (RULE8) FIFO stores stamp word with frame identifier
// (RULE9) Egress FIFO value: plus offset, Delay_req minus asymmetry
// (RULE10) Ingress 1DM to MEP: write RxTimeStampf
// (RULE11) Egress 1DM/DMM from MEP: write TxTimeStampf
// (RULE12) OAM write inserts stamp and recomputes FCS
// (RULE13) Ingress stamps subtract offset, egress stamps add
// (RULE14) Ingress DMM to MEP: write RxTimeStampf
// (RULE15) Ingress reply to MEP: write RxTimeStampb
// (RULE16) Egress reply from MEP: write TxTimeStampb
// (RULE17) Software sends empty stamps and swapped replies
// (RULE18) Recognise MPLS-TP PDUs behind tags and labels
// (RULE19) Capture local time at start of frame
// (RULE20) Unmatched frames pass unchanged, no rate change
// (RULE21) Reply opcode configurable, one reply type
`timescale 1ns/10ps
`include "tcds_defs.vh"
module tcds_stamper #(
  parameter LEAD   = `TCDS_LEAD_DEF,
  parameter FDEPTH = `TCDS_FIFO_DEPTH,
  parameter FAW    = `TCDS_FIFO_AW
) (
  input  wire        MCLK,
  input  wire        RESET,
  input  wire        EGRESS,
  input  wire [7:0]  PTP_DOMAIN,
  input  wire [2:0]  MEP_LEVEL,
  input  wire [7:0]  REPLY_OPCODE,
  input  wire [29:0] LOCAL_OFFSET,
  input  wire [29:0] ASYMMETRY,
  input  wire [31:0] TIME_SEC,
  input  wire [31:0] TIME_NS,
  input  wire [7:0]  IN_DATA,
  input  wire        IN_VALID,
  input  wire        IN_SOF,
  input  wire        IN_EOF,
  output reg  [7:0]  OUT_DATA,
  output reg         OUT_VALID,
  output reg         OUT_SOF,
  output reg         OUT_EOF,
  input  wire        FIFO_POP,
  output reg         FIFO_AVAIL,
  output reg         FIFO_FULL,
  output reg  [63:0] FIFO_STAMP,
  output reg  [79:0] FIFO_ID
);
  // ****************************************
  // Parser states
  // ****************************************
  localparam S_ETH  = 3'd0;
  localparam S_MPLS = 3'd1;
  localparam S_ACH  = 3'd2;
  localparam S_PDU  = 3'd3;
  localparam S_DONE = 3'd4;

  reg  [2:0]  st_reg;
  reg  [10:0] pos_reg;
  reg  [10:0] mark_reg;
  reg  [10:0] base_reg;
  reg  [1:0]  vlan_reg;
  reg  [1:0]  lbl_reg;
  reg         sbit_reg;
  reg  [7:0]  prev_reg;
  reg         oam_reg;
  reg  [3:0]  mtype_reg;
  reg  [2:0]  mel_reg;
  reg  [10:0] w1_off_reg;
  reg  [3:0]  w1_len_reg;
  reg         w1_full_reg;
  reg  [10:0] w2_off_reg;
  reg  [3:0]  w2_len_reg;
  reg         w2_cf_reg;
  reg         save_reg;
  reg         masym_reg;
  reg         mod_reg;
  reg  [63:0] cf_reg;
  reg  [79:0] id_reg;
  reg  [10:0] len_reg;

  wire [10:0] p = IN_SOF ? 11'd0 : pos_reg;
  wire [10:0] rel = p - base_reg;
  wire [15:0] etype = {prev_reg, IN_DATA};
  wire        is_1dm = (IN_DATA == `TCDS_OP_1DM);
  wire        is_dmm = (IN_DATA == `TCDS_OP_DMM);
  wire        is_rep = (IN_DATA == REPLY_OPCODE); // [RULE21]
  wire        ptp_evt = (mtype_reg == `TCDS_PTP_SYNC) || (mtype_reg == `TCDS_PTP_DREQ);
  wire        id_pos = (rel == `TCDS_PTP_TYPE_REL) || (rel == `TCDS_PTP_DOM_REL) ||
                       (rel >= `TCDS_PTP_RSV_REL && rel <= `TCDS_PTP_RSV_END) ||
                       (rel >= `TCDS_PTP_PORT_REL && rel <= `TCDS_PTP_SEQ_END);
  wire [31:0] stamp_sec;
  wire [31:0] stamp_ns;
  wire        save_flag;

  // ****************************************
  // Stamp unit
  // ****************************************
  tcds_stamp u_stamp (
    .clk        (MCLK),
    .rst        (RESET),
    .sof        (IN_VALID && IN_SOF),
    .time_sec   (TIME_SEC),
    .time_ns    (TIME_NS),
    .offset     (LOCAL_OFFSET),
    .asym       (ASYMMETRY),
    .subtract   (!EGRESS),
    .minus_asym (masym_reg),
    .save_req   (IN_VALID && IN_EOF && save_reg),
    .stamp_sec  (stamp_sec),
    .stamp_ns   (stamp_ns),
    .save_flag  (save_flag)
  );

  // ****************************************
  // Analyzer
  // ****************************************
  always @(posedge MCLK) begin
    if (RESET) begin
      st_reg <= S_DONE;
      pos_reg <= 11'd0;
      mark_reg <= `TCDS_ETYPE_POS;
      base_reg <= 11'd0;
      vlan_reg <= 2'd0;
      lbl_reg <= 2'd0;
      sbit_reg <= 1'b0;
      prev_reg <= 8'h00;
      oam_reg <= 1'b0;
      mtype_reg <= 4'h0;
      mel_reg <= 3'd0;
      w1_off_reg <= 11'd0;
      w1_len_reg <= 4'd0;
      w1_full_reg <= 1'b0;
      w2_off_reg <= 11'd0;
      w2_len_reg <= 4'd0;
      w2_cf_reg <= 1'b0;
      save_reg <= 1'b0;
      masym_reg <= 1'b0;
      mod_reg <= 1'b0;
      cf_reg <= 64'h0;
      id_reg <= 80'h0;
      len_reg <= 11'h7ff;
    end else if (IN_VALID) begin
      pos_reg <= p + 11'd1;
      prev_reg <= IN_DATA;
      if (IN_SOF) begin
        st_reg <= S_ETH;
        mark_reg <= `TCDS_ETYPE_POS;
        vlan_reg <= 2'd0;
        w1_len_reg <= 4'd0;
        w2_len_reg <= 4'd0;
        save_reg <= 1'b0;
        masym_reg <= 1'b0;
        mod_reg <= 1'b0; // [RULE20]
        id_reg <= 80'h0;
        len_reg <= 11'h7ff;
      end
      if (IN_EOF)
        len_reg <= p + 11'd1;
      case (st_reg)
        S_ETH: begin
          if (!IN_SOF && p == mark_reg + 11'd1) begin
            if ((etype == `TCDS_ETH_VLAN || etype == `TCDS_ETH_QINQ) &&
                vlan_reg != `TCDS_MAX_VLAN) begin
              vlan_reg <= vlan_reg + 2'd1;
              mark_reg <= mark_reg + `TCDS_VLAN_BYTES;
            end else if (etype == `TCDS_ETH_PTP || etype == `TCDS_ETH_OAM) begin
              oam_reg <= (etype == `TCDS_ETH_OAM);
              base_reg <= p + 11'd1;
              st_reg <= S_PDU;
            end else if (etype == `TCDS_ETH_MPLS) begin // [RULE18]
              lbl_reg <= 2'd0;
              mark_reg <= p + 11'd1;
              st_reg <= S_MPLS;
            end else begin
              st_reg <= S_DONE; // [RULE20]
            end
          end
        end
        S_MPLS: begin
          if (p == mark_reg + 11'd2)
            sbit_reg <= IN_DATA[0];
          if (p == mark_reg + 11'd3) begin
            mark_reg <= p + 11'd1;
            if (sbit_reg)
              st_reg <= S_ACH;
            else if (lbl_reg == `TCDS_MAX_LABEL)
              st_reg <= S_DONE;
            else
              lbl_reg <= lbl_reg + 2'd1;
          end
        end
        S_ACH: begin
          if (p == mark_reg && IN_DATA[7:4] != `TCDS_ACH_NIBBLE)
            st_reg <= S_DONE;
          if (p == mark_reg + 11'd3) begin
            if (etype == `TCDS_ACH_OAM) begin // [RULE18]
              oam_reg <= 1'b1;
              base_reg <= p + 11'd1;
              st_reg <= S_PDU;
            end else begin
              st_reg <= S_DONE;
            end
          end
        end
        S_PDU: begin
          if (!oam_reg) begin
            if (rel == `TCDS_PTP_TYPE_REL)
              mtype_reg <= IN_DATA[3:0];
            if (rel == `TCDS_PTP_DOM_REL) begin
              if (IN_DATA == PTP_DOMAIN && ptp_evt) begin
                mod_reg <= 1'b1;
                if (!EGRESS) begin
                  w1_off_reg <= base_reg + `TCDS_PTP_RSV_REL; // [RULE1]
                  w1_len_reg <= `TCDS_RSV_BYTES;
                  w1_full_reg <= 1'b0; // [RULE2]
                  if (mtype_reg == `TCDS_PTP_SYNC) begin
                    w2_off_reg <= base_reg + `TCDS_PTP_CF_REL; // [RULE3]
                    w2_len_reg <= `TCDS_CF_BYTES;
                    w2_cf_reg <= 1'b1;
                  end
                end else begin
                  w1_off_reg <= 11'd0; // [RULE4]
                  w1_len_reg <= 4'd0; // [RULE4]
                  save_reg <= 1'b1;
                  masym_reg <= (mtype_reg == `TCDS_PTP_DREQ); // [RULE9]
                  w2_off_reg <= base_reg + `TCDS_PTP_RSV_REL; // [RULE6]
                  w2_len_reg <= `TCDS_RSV_BYTES;
                  w2_cf_reg <= 1'b0;
                end
              end else begin
                st_reg <= S_DONE;
              end
            end
            if (rel >= `TCDS_PTP_CF_REL && rel <= `TCDS_PTP_CF_END)
              cf_reg <= {cf_reg[55:0], IN_DATA};
            if (id_pos)
              id_reg <= {id_reg[71:0], IN_DATA}; // [RULE5]
            if (rel == `TCDS_PTP_SEQ_END)
              st_reg <= S_DONE;
          end else begin
            if (rel == `TCDS_OAM_MEL_REL)
              mel_reg <= IN_DATA[7:5];
            if (rel == `TCDS_OAM_OP_REL) begin
              st_reg <= S_DONE;
              if (mel_reg == MEP_LEVEL && (is_1dm || is_dmm || is_rep)) begin
                mod_reg <= 1'b1; // [RULE12]
                w1_len_reg <= `TCDS_STAMP_BYTES;
                w1_full_reg <= 1'b1;
                if (!EGRESS && is_rep)
                  w1_off_reg <= base_reg + `TCDS_OAM_RXB_REL; // [RULE15]
                else if (!EGRESS)
                  w1_off_reg <= base_reg + `TCDS_OAM_RXF_REL; // [RULE10] [RULE14]
                else if (is_rep)
                  w1_off_reg <= base_reg + `TCDS_OAM_TXB_REL; // [RULE16]
                else
                  w1_off_reg <= base_reg + `TCDS_OAM_TXF_REL; // [RULE11]
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Delay line ahead of the rewriter
  // ****************************************
  reg [7:0] dly_data_reg [0:LEAD-1];
  reg       dly_v_reg    [0:LEAD-1];
  reg       dly_sof_reg  [0:LEAD-1];
  reg       dly_eof_reg  [0:LEAD-1];
  integer   k;
  always @(posedge MCLK) begin
    for (k = 0; k < LEAD; k = k + 1) begin
      if (RESET) begin
        dly_data_reg[k] <= 8'h00;
        dly_v_reg[k] <= 1'b0;
        dly_sof_reg[k] <= 1'b0;
        dly_eof_reg[k] <= 1'b0;
      end else if (k == 0) begin
        dly_data_reg[k] <= IN_DATA;
        dly_v_reg[k] <= IN_VALID;
        dly_sof_reg[k] <= IN_VALID && IN_SOF;
        dly_eof_reg[k] <= IN_VALID && IN_EOF;
      end else begin
        dly_data_reg[k] <= dly_data_reg[k-1];
        dly_v_reg[k] <= dly_v_reg[k-1];
        dly_sof_reg[k] <= dly_sof_reg[k-1];
        dly_eof_reg[k] <= dly_eof_reg[k-1];
      end
    end
  end

  // ****************************************
  // Rewriter and FCS regeneration
  // ****************************************
  reg  [10:0] opos_reg;
  reg  [31:0] crc_reg;
  wire        d_v = dly_v_reg[LEAD-1];
  wire        d_sof = dly_sof_reg[LEAD-1];
  wire [10:0] po = d_sof ? 11'd0 : opos_reg;
  wire [10:0] o1 = po - w1_off_reg;
  wire [10:0] o2 = po - w2_off_reg;
  wire        h1 = (po >= w1_off_reg) && (o1 < {7'd0, w1_len_reg});
  wire        h2 = (po >= w2_off_reg) && (o2 < {7'd0, w2_len_reg});
  wire [63:0] v1 = w1_full_reg ? {stamp_sec, stamp_ns} : {stamp_ns, 32'h0};
  wire [63:0] v2 = w2_cf_reg ? (cf_reg + {18'h0, ASYMMETRY, 16'h0}) : 64'h0;
  wire [63:0] sh1 = v1 << {o1[2:0], 3'b000};
  wire [63:0] sh2 = v2 << {o2[2:0], 3'b000};
  wire [10:0] fcs_pos = len_reg - `TCDS_FCS_BYTES;
  wire [10:0] fb = po - fcs_pos;
  wire        in_fcs = mod_reg && (len_reg != 11'h7ff) && (po >= fcs_pos);
  wire [31:0] crc_inv = ~crc_reg >> {fb[1:0], 3'b000};
  wire [31:0] crc_base = d_sof ? `TCDS_CRC_INIT : crc_reg;
  wire [31:0] crc_nxt;
  reg  [7:0]  new_byte;

  always @* begin
    if (in_fcs)
      new_byte = crc_inv[7:0]; // [RULE2] [RULE12]
    else if (h1)
      new_byte = sh1[63:56]; // [RULE2] [RULE12]
    else if (h2)
      new_byte = sh2[63:56]; // [RULE3] [RULE6]
    else
      new_byte = dly_data_reg[LEAD-1]; // [RULE20]
  end

  tcds_crc32 u_crc (
    .crc_in  (crc_base),
    .data    (new_byte),
    .crc_out (crc_nxt)
  );

  always @(posedge MCLK) begin
    if (RESET) begin
      opos_reg <= 11'd0;
      crc_reg <= `TCDS_CRC_INIT;
      OUT_DATA <= 8'h00;
      OUT_VALID <= 1'b0;
      OUT_SOF <= 1'b0;
      OUT_EOF <= 1'b0;
    end else begin
      if (d_v) begin
        opos_reg <= po + 11'd1;
        if (!in_fcs)
          crc_reg <= crc_nxt;
      end
      OUT_DATA <= d_v ? new_byte : 8'h00;
      OUT_VALID <= d_v;
      OUT_SOF <= d_sof;
      OUT_EOF <= dly_eof_reg[LEAD-1];
    end
  end

  // ****************************************
  // Tx stamp FIFO
  // ****************************************
  reg  [143:0] fifo_mem [0:FDEPTH-1];
  reg  [FAW:0] wp_reg;
  reg  [FAW:0] rp_reg;
  wire         pop = FIFO_POP && FIFO_AVAIL;
  wire [FAW:0] rp_next = pop ? rp_reg + 1'b1 : rp_reg;
  wire [FAW:0] used = wp_reg - rp_reg;
  wire         can_wr = (used != FDEPTH[FAW:0]);
  wire         wr = save_flag && can_wr;
  wire [FAW:0] wp_next = wr ? wp_reg + 1'b1 : wp_reg;
  wire [FAW:0] used_next = wp_next - rp_next;

  always @(posedge MCLK) begin
    if (wr)
      fifo_mem[wp_reg[FAW-1:0]] <= {stamp_sec, stamp_ns, id_reg}; // [RULE7] [RULE8] [RULE9]
  end

  always @(posedge MCLK) begin
    if (RESET) begin
      wp_reg <= {(FAW+1){1'b0}};
      rp_reg <= {(FAW+1){1'b0}};
      FIFO_AVAIL <= 1'b0;
      FIFO_FULL <= 1'b0;
      FIFO_STAMP <= 64'h0;
      FIFO_ID <= 80'h0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      FIFO_AVAIL <= (wp_reg != rp_next);
      FIFO_FULL <= (used_next == FDEPTH[FAW:0]);
      {FIFO_STAMP, FIFO_ID} <= fifo_mem[rp_next[FAW-1:0]];
    end
  end
endmodule // tcds_stamper

//--- verif/tcds_host.sv
// Host model that drains the Tx stamp FIFO, with a stall input
`timescale 1ns/10ps
module tcds_host (
  input  logic clk,
  input  logic rst,
  input  logic hold,
  input  logic avail,
  output logic pop
);
  // ****************************************
  // One-cycle pop, then one idle edge
  // ****************************************
  always @(posedge clk) begin
    if (rst)
      pop <= 1'b0;
    else
      pop <= !pop && avail && !hold;
  end
endmodule // tcds_host

//--- verif/tcds_stamper_properties.sv
// Checker for stream latency and stamp FIFO behaviour of the stamper
`timescale 1ns/10ps
module tcds_props #(
  parameter LEAD = 8
) (
  input logic        MCLK,
  input logic        RESET,
  input logic        EGRESS,
  input logic [7:0]  IN_DATA,
  input logic        IN_VALID,
  input logic        IN_SOF,
  input logic        IN_EOF,
  input logic [7:0]  OUT_DATA,
  input logic        OUT_VALID,
  input logic        OUT_SOF,
  input logic        OUT_EOF,
  input logic        FIFO_POP,
  input logic        FIFO_AVAIL,
  input logic        FIFO_FULL,
  input logic [63:0] FIFO_STAMP,
  input logic [79:0] FIFO_ID
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  // ****************************************
  // Stream and FIFO properties
  // ****************************************
  sequence s_out_first; OUT_VALID && OUT_SOF; endsequence
  sequence s_out_mid; OUT_VALID && !OUT_EOF; endsequence
  sequence s_head_waits; FIFO_AVAIL && !FIFO_POP; endsequence
  property p_lat_v; OUT_VALID == $past(IN_VALID, LEAD + 1); endproperty
  property p_lat_e; OUT_EOF == $past(IN_EOF, LEAD + 1); endproperty
  property p_lat_s; OUT_SOF == $past(IN_VALID && IN_SOF, LEAD + 1); endproperty
  property p_first;
    s_out_first |-> $past(IN_SOF, LEAD + 1) && OUT_DATA == $past(IN_DATA, LEAD + 1);
  endproperty
  property p_idle; !OUT_VALID |-> OUT_DATA == 8'h00; endproperty
  property p_run; s_out_mid |=> OUT_VALID; endproperty
  property p_hold;
    s_head_waits |=> FIFO_AVAIL && $stable(FIFO_STAMP) && $stable(FIFO_ID);
  endproperty
  property p_full; FIFO_FULL |-> FIFO_AVAIL; endproperty
  property p_no_rx_save; !EGRESS && !$past(EGRESS, 4) && !FIFO_AVAIL |=> !FIFO_AVAIL; endproperty
  a_lat_v: assert property (p_lat_v) else $error("valid latency");
  a_lat_e: assert property (p_lat_e) else $error("end latency");
  a_lat_s: assert property (p_lat_s) else $error("start latency");
  a_first: assert property (p_first) else $error("first byte");
  a_idle: assert property (p_idle) else $error("idle data");
  a_run: assert property (p_run) else $error("gap in frame");
  a_hold: assert property (p_hold) else $error("head moved");
  a_full: assert property (p_full) else $error("full but empty");
  a_no_rx_save: assert property (p_no_rx_save) else $error("ingress save");
endmodule // tcds_props

bind tcds_stamper tcds_props #(.LEAD(LEAD)) u_props (
  .MCLK, .RESET, .EGRESS, .IN_DATA, .IN_VALID, .IN_SOF, .IN_EOF, .OUT_DATA, .OUT_VALID,
  .OUT_SOF, .OUT_EOF, .FIFO_POP, .FIFO_AVAIL, .FIFO_FULL, .FIFO_STAMP, .FIFO_ID
);

//--- verif/tcds_stamper_test.sv
// Self-checking bench for the two-step stamper
`timescale 1ns/10ps
module tcds_stamper_test;
  localparam int     N  = 80;
  localparam longint NS = 1000000000;
  logic         MCLK, RESET, EGRESS, IN_VALID, IN_SOF, IN_EOF, hold;
  logic         OUT_VALID, OUT_SOF, OUT_EOF, FIFO_POP, FIFO_AVAIL, FIFO_FULL;
  logic [7:0]   PTP_DOMAIN, REPLY_OPCODE, IN_DATA, OUT_DATA, dom, fr[N], ex[N];
  logic [2:0]   MEP_LEVEL, mel;
  logic [29:0]  LOCAL_OFFSET, ASYMMETRY, off, asy;
  logic [31:0]  TIME_SEC, TIME_NS, tsec, tns, seed;
  logic [63:0]  FIFO_STAMP;
  logic [79:0]  FIFO_ID;
  logic [7:0]   outq[$];
  logic [143:0] gotq[$], expq[$];
  int           mismatches, cmp_count;

  tcds_stamper #(.FDEPTH(2), .FAW(1)) DUT (
    .MCLK, .RESET, .EGRESS, .PTP_DOMAIN, .MEP_LEVEL, .REPLY_OPCODE, .LOCAL_OFFSET,
    .ASYMMETRY, .TIME_SEC, .TIME_NS, .IN_DATA, .IN_VALID, .IN_SOF, .IN_EOF, .OUT_DATA,
    .OUT_VALID, .OUT_SOF, .OUT_EOF, .FIFO_POP, .FIFO_AVAIL, .FIFO_FULL, .FIFO_STAMP, .FIFO_ID
  );
  tcds_host HOST (.clk(MCLK), .rst(RESET), .hold(hold), .avail(FIFO_AVAIL), .pop(FIFO_POP));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    if (OUT_VALID === 1'b1)
      outq.push_back(OUT_DATA);
    if (FIFO_POP === 1'b1 && FIFO_AVAIL === 1'b1)
      gotq.push_back({FIFO_STAMP, FIFO_ID});
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [143:0] seen, input logic [143:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [63:0] stamp(input logic sub, input logic masy);
    longint t;
    t = tsec * NS + tns;
    t = sub ? t - off : t + off - (masy ? asy : 30'h0);
    return {32'(t / NS), 32'(t % NS)};
  endfunction

  task automatic put(input int pos, input logic [63:0] v, input int nb);
    for (int i = 0; i < nb; i++)
      ex[pos + i] = v[8 * (nb - 1 - i) +: 8];
  endtask

  task automatic send();
    for (int i = 0; i < N; i++) begin
      @(posedge MCLK);
      IN_VALID <= 1'b1;
      IN_SOF <= i == 0;
      IN_EOF <= i == N - 1;
      IN_DATA <= fr[i];
      if (i == 1) begin
        TIME_SEC <= ~tsec;
        TIME_NS <= 32'($urandom % NS);
      end
    end
    @(posedge MCLK);
    {IN_VALID, IN_EOF, IN_DATA} <= '0;
    repeat (12) @(posedge MCLK);
  endtask

  // ****************************************
  // One frame: build, predict, send, compare
  // ****************************************
  task automatic run(input logic eg, input int enc, input int typ);
    int p;
    int q;
    logic ptp;
    logic hit;
    logic [63:0] ts;
    logic [63:0] cf;
    logic [79:0] id;
    int ids[10] = '{0, 4, 16, 17, 18, 19, 28, 29, 30, 31};
    ptp = typ < 2 || typ == 5;
    dom = 8'($urandom);
    mel = 3'($urandom);
    off = 30'($urandom % NS);
    asy = 30'($urandom % NS);
    tsec = $urandom | 32'h1;
    tns = ($urandom % 3 == 0) ? 32'h0 : ($urandom % 2) ? 32'd999999999 : 32'($urandom % NS);
    for (int i = 0; i < N; i++)
      fr[i] = 8'($urandom);
    q = enc > 0 ? 16 : 12;
    if (enc > 0)
      {fr[12], fr[13]} = 16'h8100;
    {fr[q], fr[q + 1]} = ptp ? 16'h88f7 : enc == 2 ? 16'h8847 : 16'h8902;
    p = q + 2;
    if (enc == 2) begin
      fr[q + 2] = fr[q + 2] | 8'h80;
      fr[q + 4] = fr[q + 4] & 8'hfe;
      fr[q + 6] = fr[q + 6] | 8'h80;
      fr[q + 8] = fr[q + 8] | 8'h01;
      {fr[q + 10], fr[q + 11], fr[q + 12], fr[q + 13]} = 32'h10008902;
      p = q + 14;
    end
    if (ptp) begin
      fr[p] = {fr[p][7:4], typ == 5 ? (eg ? 4'h0 : 4'h8) : 4'(typ)};
      fr[p + 4] = (typ == 5 && eg) ? ~dom : dom;
    end else begin
      fr[p] = {typ == 6 ? ~mel : mel, fr[p][4:0]};
      fr[p + 1] = typ == 2 ? 8'h2d : typ == 4 ? (eg ? 8'h2e : 8'h31) : 8'h2f;
      for (int i = 4; i < 36; i++)
        fr[p + i] = 8'h00;
    end
    ex = fr;
    id = 80'h0;
    foreach (ids[i])
      id = {id[71:0], fr[p + ids[i]]};
    ts = stamp(!eg, typ == 1);
    hit = 1'b1;
    if (ptp && typ != 5 && !eg) begin
      put(p + 16, ts[31:0], 4);
      cf = 64'h0;
      for (int i = 8; i < 16; i++)
        cf = {cf[55:0], fr[p + i]};
      if (typ == 0)
        put(p + 8, cf + {asy, 16'h0}, 8);
    end else if (ptp && typ != 5) begin
      put(p + 16, 64'h0, 4);
      expq.push_back({ts, id});
    end else if (typ > 1 && typ < 5) begin
      put(p + (typ == 4 ? 20 : 4) + (eg ? 0 : 8), ts, 8);
    end else
      hit = 1'b0;
    if (hit) begin
      cf = 64'hffffffff;
      for (int i = 0; i < N - 4; i++) begin
        cf[31:0] = cf[31:0] ^ ex[i];
        repeat (8)
          cf[31:0] = cf[0] ? (cf[31:0] >> 1) ^ 32'hedb88320 : cf[31:0] >> 1;
      end
      put(N - 4, {32'h0, ~cf[7:0], ~cf[15:8], ~cf[23:16], ~cf[31:24]}, 4);
    end
    @(posedge MCLK);
    EGRESS <= eg;
    PTP_DOMAIN <= dom;
    MEP_LEVEL <= mel;
    REPLY_OPCODE <= eg ? 8'h2e : 8'h31;
    LOCAL_OFFSET <= off;
    ASYMMETRY <= asy;
    TIME_SEC <= tsec;
    TIME_NS <= tns;
    send();
    check(outq.size(), N);
    foreach (ex[i])
      check(outq[i], ex[i]);
    outq.delete();
    while (gotq.size() > 0 && expq.size() > 0)
      check(gotq.pop_front(), expq.pop_front());
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    seed = $urandom(16685);
    RESET = 1'b1;
    {EGRESS, IN_VALID, IN_SOF, IN_EOF, hold} = '0;
    {PTP_DOMAIN, MEP_LEVEL, REPLY_OPCODE, LOCAL_OFFSET, ASYMMETRY, TIME_SEC, TIME_NS} = '0;
    IN_DATA = 8'h00;
    repeat (10) @(posedge MCLK);
    RESET <= 1'b0;
    for (int e = 0; e < 2; e++)
      for (int c = 0; c < 3; c++)
        for (int t = 0; t < 7; t++)
          if (c < 2 || !(t < 2 || t == 5))
            run(e[0], c, t);
    hold <= 1'b1;
    repeat (3)
      run(1'b1, 0, 0);
    check(FIFO_FULL, 1'b1);
    void'(expq.pop_back());
    hold <= 1'b0;
    repeat (20) @(posedge MCLK);
    while (expq.size() > 0)
      check(gotq.pop_front(), expq.pop_front());
    check(gotq.size(), 0);
    final_report();
  end

  initial begin
    repeat (10000) @(posedge MCLK);
    mismatches++;
    final_report();
  end
endmodule // tcds_stamper_test
